// >>> qhpm_pkg.sv
/*
  Shared constants for the quarter-hour performance-monitoring accumulator.
  Assumes one system clock; ticks arrive as one-cycle pulses on that clock.
*/
package qhpm_pkg;
  localparam int NOMINAL_S       = 900;
  localparam int DOUBT_TOL_S     = 10;
  localparam int HIST_SLOTS      = 16;
  localparam int HIST_SEL_W      = 4;
  localparam int CAP_ES          = 900;
  localparam int CAP_UAS         = 900;
  localparam int CAP_SES         = 810;
  localparam int CAP_BBE_HO      = 2160000;
  localparam int CAP_BBE_CRC30   = 270000;
  localparam int CAP_BBE_CRC805  = 724500;
  localparam int CNT_W_DEF       = 22;
  localparam int ELAPSED_W_DEF   = 10;
  localparam int EVENT_W_DEF     = 16;
  localparam int OFFSET_W        = 18;
endpackage : qhpm_pkg

// >>> qhpm_history.sv
/*
  Sixteen-slot shift chain of finished quarter-hour intervals, slot 0 newest.
  Assumes push is a one-cycle pulse from the accumulator.
*/
`timescale 1ns/1ns
`default_nettype none
module qhpm_history #(
  parameter int CNT_W = qhpm_pkg::CNT_W_DEF,
  parameter int ELW   = qhpm_pkg::ELAPSED_W_DEF
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        init_in,
  input  wire logic                        push_in,
  input  wire logic [CNT_W-1:0]            push_count_in,
  input  wire logic [ELW-1:0]              push_elapsed_in,
  input  wire logic                        push_doubt_in,
  input  wire logic [qhpm_pkg::HIST_SEL_W-1:0] sel_in,
  output logic [CNT_W-1:0]                 history_slot_counts_out,
  output logic [ELW-1:0]                   history_elapsed_out,
  output logic                             history_doubt_out
);
  import qhpm_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [ELW-1:0]   elapsed;
    logic             doubt;
  } qhpm_slot_s;

  typedef struct packed {
    qhpm_slot_s [HIST_SLOTS-1:0] slot;
    qhpm_slot_s                  rd;
  } qhpm_hist_s;

  qhpm_hist_s state_reg;
  qhpm_hist_s state_next;

  always_comb begin
    state_next = state_reg;
    if (init_in) begin
      for (int i = 0; i < HIST_SLOTS; i++) begin
        state_next.slot[i] = '{count: '0, elapsed: '0, doubt: 1'b1};
      end
    end else if (push_in) begin
      // Oldest slot falls off the end
      for (int i = HIST_SLOTS-1; i > 0; i--) begin // RULE16
        state_next.slot[i] = state_reg.slot[i-1];
      end
      state_next.slot[0] = '{count: push_count_in, elapsed: push_elapsed_in,
                             doubt: push_doubt_in}; // RULE11
    end
    state_next.rd = state_reg.slot[sel_in];
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign history_slot_counts_out = state_reg.rd.count;
  assign history_elapsed_out     = state_reg.rd.elapsed;
  assign history_doubt_out       = state_reg.rd.doubt;
endmodule : qhpm_history
`default_nettype wire

// >>> qhpm_accumulator.sv
/*
  Current quarter-hour register: saturating event count, elapsed seconds,
  data-doubt flag, hand-over into a sixteen-slot history at each boundary.
  Assumes ticks and presets are one-cycle pulses on clk_sys_in, derived from
  the element time-of-day clock, and that the event value is valid with
  second_tick_in.
*/
// What this block does
// (RULE1) Add event value each processed second
// (RULE2) Count saturates, holds until cleared or handed
// (RULE3) Count spans zero to nominal interval count
// (RULE4) Capacity meets per-layer sizing table minimum
// (RULE5) 2M CRC capacity 270000 or 724500
// (RULE6) Doubt flag when elapsed off 900 by >10
// (RULE7) Preset beyond 10 s sets doubt flag
// (RULE8) Data loss or initialisation sets doubt flag
// (RULE9) Elapsed field counts processed seconds, >=900
// (RULE10) Elapsed saturates, holds until cleared or handed
// (RULE11) Period end: hand over, then clear
// (RULE12) Time set outside interval ends period
// (RULE13) New period: elapsed, flag, count zero
// (RULE14) Start of processing clears all fields
// (RULE15) Current values readable on report request
// (RULE16) Hand-over lands in slot zero, chain shifts
// (RULE17) Second tick qualifies, quarter tick bounds
// (RULE18) Boundary-second value counts in fresh interval
`timescale 1ns/1ns
`default_nettype none
module qhpm_accumulator #(
  parameter int CNT_W     = qhpm_pkg::CNT_W_DEF,
  parameter int ELW       = qhpm_pkg::ELAPSED_W_DEF,
  parameter int EVENT_W   = qhpm_pkg::EVENT_W_DEF,
  parameter int MIN_COUNT = qhpm_pkg::CAP_BBE_HO
) (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_in,
  input  wire logic                            start_in,
  input  wire logic                            second_tick_in,
  input  wire logic                            quarter_hour_tick_in,
  input  wire logic [EVENT_W-1:0]              interval_event_input_in,
  input  wire logic                            time_preset_in,
  input  wire logic signed [qhpm_pkg::OFFSET_W-1:0] time_preset_offset_in,
  input  wire logic                            time_preset_outside_in,
  input  wire logic                            data_loss_in,
  input  wire logic                            report_req_in,
  input  wire logic [qhpm_pkg::HIST_SEL_W-1:0] history_sel_in,
  output logic [CNT_W-1:0]                     quarter_hour_count_out,
  output logic [ELW-1:0]                       elapsed_time_out,
  output logic                                 data_doubt_flag_out,
  output logic                                 report_valid_out,
  output logic [CNT_W-1:0]                     report_count_out,
  output logic [ELW-1:0]                       report_elapsed_out,
  output logic                                 report_doubt_out,
  output logic [CNT_W-1:0]                     history_slot_counts_out,
  output logic [ELW-1:0]                       history_elapsed_out,
  output logic                                 history_doubt_out
);
  import qhpm_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [ELW-1:0]   EL_MAX  = '1;
  localparam logic [ELW-1:0]   EL_LOW  = ELW'(NOMINAL_S - DOUBT_TOL_S);
  localparam logic [ELW-1:0]   EL_HIGH = ELW'(NOMINAL_S + DOUBT_TOL_S);
  localparam logic [OFFSET_W-1:0] TOL_OFS = OFFSET_W'(DOUBT_TOL_S);

  // Capacity must cover the monitored parameter's interval count
  if ((64'(1) << CNT_W) - 64'(1) < 64'(MIN_COUNT)) begin : g_cnt_narrow // RULE3 RULE4 RULE5
    $error("CNT_W too narrow for MIN_COUNT");
  end
  if ((64'(1) << ELW) - 64'(1) < 64'(NOMINAL_S + DOUBT_TOL_S)) begin : g_el_narrow // RULE9
    $error("ELW too narrow for elapsed time");
  end
  if (EVENT_W > CNT_W || EVENT_W < 1) begin : g_event_width
    $error("EVENT_W must be 1..CNT_W");
  end

  typedef struct packed {
    logic             active;
    logic             first;
    logic [CNT_W-1:0] count;
    logic [ELW-1:0]   elapsed;
    logic             doubt;
    logic             rep_valid;
    logic [CNT_W-1:0] rep_count;
    logic [ELW-1:0]   rep_elapsed;
    logic             rep_doubt;
  } qhpm_acc_s;

  qhpm_acc_s state_reg;
  qhpm_acc_s state_next;

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] base,
                                               input logic [EVENT_W-1:0] ev);
    logic [CNT_W:0] sum;
    sum = {1'b0, base} + (CNT_W+1)'(ev);
    sat_add = sum[CNT_W] ? CNT_MAX : sum[CNT_W-1:0];
  endfunction : sat_add

  function automatic logic off_nominal(input logic [ELW-1:0] el);
    off_nominal = (el < EL_LOW) || (el > EL_HIGH);
  endfunction : off_nominal

  logic                period_end;
  logic                big_preset;
  logic [OFFSET_W-1:0] ofs_mag;
  logic                push_doubt;

  assign ofs_mag    = time_preset_offset_in[OFFSET_W-1] ?
                      OFFSET_W'(-time_preset_offset_in) : time_preset_offset_in;
  assign big_preset = time_preset_in && (ofs_mag > TOL_OFS); // RULE7
  assign period_end = state_reg.active &&
                      (quarter_hour_tick_in || time_preset_outside_in); // RULE12 RULE17
  // Interval handed over is doubtful if it ran off nominal or began mid-period
  assign push_doubt = state_reg.doubt || state_reg.first ||
                      off_nominal(state_reg.elapsed); // RULE6 RULE8

  always_comb begin
    state_next = state_reg;
    state_next.rep_valid = 1'b0;
    if (start_in) begin
      state_next.active  = 1'b1;
      state_next.first   = 1'b1;
      state_next.count   = '0; // RULE14
      state_next.elapsed = '0;
      state_next.doubt   = 1'b0;
    end else if (state_reg.active) begin
      if (period_end) begin
        state_next.first = 1'b0;
        state_next.doubt = 1'b0; // RULE13
        if (second_tick_in) begin
          state_next.count   = sat_add('0, interval_event_input_in); // RULE18
          state_next.elapsed = ELW'(1);
        end else begin
          state_next.count   = '0; // RULE11
          state_next.elapsed = '0;
        end
      end else if (second_tick_in) begin
        state_next.count = sat_add(state_reg.count, interval_event_input_in); // RULE1 RULE2
        if (state_reg.elapsed != EL_MAX) begin // RULE10
          state_next.elapsed = state_reg.elapsed + ELW'(1); // RULE9
        end
      end
      // Setting events win over the period clear
      if (big_preset || data_loss_in) begin
        state_next.doubt = 1'b1; // RULE7 RULE8
      end
      if (!period_end && state_reg.elapsed > EL_HIGH) begin
        state_next.doubt = 1'b1; // RULE6
      end
    end
    if (report_req_in) begin
      state_next.rep_valid   = 1'b1; // RULE15
      state_next.rep_count   = state_reg.count;
      state_next.rep_elapsed = state_reg.elapsed;
      state_next.rep_doubt   = state_reg.doubt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign quarter_hour_count_out = state_reg.count;
  assign elapsed_time_out       = state_reg.elapsed;
  assign data_doubt_flag_out    = state_reg.doubt;
  assign report_valid_out       = state_reg.rep_valid;
  assign report_count_out       = state_reg.rep_count;
  assign report_elapsed_out     = state_reg.rep_elapsed;
  assign report_doubt_out       = state_reg.rep_doubt;

  qhpm_history #(
    .CNT_W (CNT_W),
    .ELW   (ELW)
  ) u_history (
    .clk_sys_in              (clk_sys_in),
    .rst_in                  (rst_in),
    .init_in                 (start_in),
    .push_in                 (period_end && !start_in),
    .push_count_in           (state_reg.count),
    .push_elapsed_in         (state_reg.elapsed),
    .push_doubt_in           (push_doubt),
    .sel_in                  (history_sel_in),
    .history_slot_counts_out (history_slot_counts_out),
    .history_elapsed_out     (history_elapsed_out),
    .history_doubt_out       (history_doubt_out)
  );

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  logic plain_sec;
  assign plain_sec = state_reg.active && !start_in && second_tick_in && !period_end;

  a_sec_accum: assert property ( // RULE1
    plain_sec && state_reg.count <= CNT_MAX - CNT_W'(interval_event_input_in)
    |=> quarter_hour_count_out == $past(state_reg.count) + CNT_W'($past(interval_event_input_in)))
    else $error("count did not add event value");

  a_count_saturate: assert property ( // RULE2
    plain_sec && state_reg.count == CNT_MAX |=> quarter_hour_count_out == CNT_MAX)
    else $error("saturated count moved");

  a_elapsed_step: assert property ( // RULE9
    plain_sec && state_reg.elapsed != EL_MAX |=> elapsed_time_out == $past(state_reg.elapsed) + ELW'(1))
    else $error("elapsed did not step");

  a_elapsed_hold: assert property ( // RULE10
    plain_sec && state_reg.elapsed == EL_MAX |=> elapsed_time_out == EL_MAX)
    else $error("saturated elapsed moved");

  a_end_clears: assert property ( // RULE13
    period_end && !start_in && !second_tick_in && !time_preset_in && !data_loss_in
    |=> quarter_hour_count_out == '0 && elapsed_time_out == '0 && !data_doubt_flag_out)
    else $error("period end did not clear");

  a_fresh_second: assert property ( // RULE18
    period_end && !start_in && second_tick_in
    |=> elapsed_time_out == ELW'(1) && quarter_hour_count_out == CNT_W'($past(interval_event_input_in)))
    else $error("boundary second not in fresh interval");

  a_preset_doubt: assert property ( // RULE7
    state_reg.active && !start_in && big_preset |=> data_doubt_flag_out)
    else $error("large preset did not raise doubt");

  a_small_preset: assert property ( // RULE7
    state_reg.active && !start_in && time_preset_in && ofs_mag <= TOL_OFS && !period_end
    && !data_loss_in && state_reg.elapsed <= EL_HIGH
    |=> data_doubt_flag_out == $past(state_reg.doubt))
    else $error("small preset changed doubt");

  a_loss_doubt: assert property ( // RULE8
    state_reg.active && !start_in && data_loss_in |=> data_doubt_flag_out)
    else $error("data loss did not raise doubt");

  a_start_clears: assert property ( // RULE14
    start_in |=> quarter_hour_count_out == '0 && elapsed_time_out == '0
    && !data_doubt_flag_out ##1 1'b1)
    else $error("start did not clear");

  a_report_copy: assert property ( // RULE15
    report_req_in |=> report_valid_out && report_count_out == $past(state_reg.count)
    && report_elapsed_out == $past(state_reg.elapsed))
    else $error("report did not copy current values");

  a_handover_slot: assert property ( // RULE11
    period_end && !start_in && history_sel_in == '0 ##1 history_sel_in == '0
    |=> history_slot_counts_out == $past(state_reg.count, 2))
    else $error("hand-over missing from first slot");

  // Hand-over lands in slot 0, visible two edges after the boundary
  a_outside_handover: assert property ( // RULE12
    state_reg.active && !start_in && time_preset_outside_in && history_sel_in == '0
    ##1 history_sel_in == '0 |=> history_slot_counts_out == $past(state_reg.count, 2))
    else $error("time set outside interval did not hand over");

  a_handover_elapsed: assert property ( // RULE11
    period_end && !start_in && history_sel_in == '0 ##1 history_sel_in == '0
    |=> history_elapsed_out == $past(state_reg.elapsed, 2))
    else $error("hand-over elapsed missing from first slot");

  // Incomplete or off-nominal intervals leave the chain marked doubtful
  a_push_doubt: assert property ( // RULE6 RULE8
    period_end && !start_in && history_sel_in == '0
    && (state_reg.first || state_reg.elapsed < EL_LOW || state_reg.elapsed > EL_HIGH)
    ##1 history_sel_in == '0 |=> history_doubt_out)
    else $error("doubtful interval handed over as sound");

  a_live_overrun: assert property ( // RULE6
    state_reg.active && !start_in && !period_end && state_reg.elapsed > EL_HIGH
    |=> data_doubt_flag_out)
    else $error("overrun interval not marked doubtful");

  a_loss_at_end: assert property ( // RULE8
    period_end && !start_in && data_loss_in |=> data_doubt_flag_out)
    else $error("boundary clear beat data-loss doubt");

  // Count, elapsed and doubt stay clear until processing starts
  a_idle_quiet: assert property ( // RULE17
    !state_reg.active && !start_in
    |=> quarter_hour_count_out == '0 && elapsed_time_out == '0 && !data_doubt_flag_out)
    else $error("inactive register changed");

  // Snapshot is a one-cycle strobe over standing data
  a_report_pulse: assert property ( // RULE15
    !report_req_in |=> !report_valid_out)
    else $error("report valid without request");

  a_report_stands: assert property ( // RULE15
    !report_req_in |=> $stable(report_count_out) && $stable(report_elapsed_out)
    && $stable(report_doubt_out))
    else $error("report snapshot moved without request");

  c_full_period: cover property (period_end && state_reg.elapsed == ELW'(NOMINAL_S));
  c_saturated:   cover property (plain_sec && state_reg.count == CNT_MAX);
  c_outside_set: cover property (state_reg.active && time_preset_outside_in);
  c_report:      cover property (report_req_in ##1 report_valid_out);
  c_loss_at_end: cover property (period_end && data_loss_in);
endmodule : qhpm_accumulator
`default_nettype wire

// >>> qhpm_upstream_model.sv
/*
  Upstream filter stand-in: issues one-second ticks with their event value.
  Assumes send_in is driven by the bench away from the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module qhpm_upstream_model #(
  parameter int EVENT_W = 16
) (
  input  wire logic               clk_sys_in,
  input  wire logic               send_in,
  input  wire logic [EVENT_W-1:0] value_in,
  output logic                    second_tick_out,
  output logic [EVENT_W-1:0]      event_out
);
  logic [EVENT_W-1:0] last_reg = '0;
  always_ff @(posedge clk_sys_in) begin
    if (send_in) begin
      last_reg <= value_in;
    end
  end
  // Value only means something with the tick; otherwise show the inverse
  assign second_tick_out = send_in;
  assign event_out       = send_in ? value_in : ~last_reg;
endmodule : qhpm_upstream_model
`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench for the quarter-hour accumulator.
  Assumes the accumulator's default widths and one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import qhpm_pkg::*;
  localparam int CW   = CNT_W_DEF;
  localparam int EW   = ELAPSED_W_DEF;
  localparam int CMAX = 2**CW - 1;
  localparam int EMAX = 2**EW - 1;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic st = 0, qt = 0, pre = 0, outs = 0, loss = 0, rreq = 0, sreq = 0;
  logic p_st = 0, p_q = 0, p_pre = 0, p_out = 0, p_loss = 0, p_r = 0, p_s = 0;
  logic [EVENT_W_DEF-1:0] sval = '0, p_v = '0, ev;
  logic signed [OFFSET_W-1:0] offs = '0, p_off = '0;
  logic [HIST_SEL_W-1:0] sel = '0, p_sel = '0;
  logic stick, dbt, rv, rdbt, hdbt, ed = 0, first = 0, hd, ld;
  logic [CW-1:0] cnt, rcnt, hcnt;
  logic [EW-1:0] el, rel, hel;
  int ec = 0, ee = 0, hc, he, lc, le;
  int error_cnt = 0, total_checks = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  qhpm_upstream_model u_qhpm_upstream_model (.clk_sys_in(clk_sys_in), .send_in(sreq),
    .value_in(sval), .second_tick_out(stick), .event_out(ev));
  qhpm_accumulator u_qhpm_accumulator (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .start_in(st), .second_tick_in(stick), .quarter_hour_tick_in(qt),
    .interval_event_input_in(ev), .time_preset_in(pre), .time_preset_offset_in(offs),
    .time_preset_outside_in(outs), .data_loss_in(loss), .report_req_in(rreq),
    .history_sel_in(sel), .quarter_hour_count_out(cnt), .elapsed_time_out(el),
    .data_doubt_flag_out(dbt), .report_valid_out(rv), .report_count_out(rcnt),
    .report_elapsed_out(rel), .report_doubt_out(rdbt), .history_slot_counts_out(hcnt),
    .history_elapsed_out(hel), .history_doubt_out(hdbt));

  function automatic int sat(input int v, input int m);
    return (v > m) ? m : v;
  endfunction : sat

  function automatic logic off_nom(input int e);
    return (e < NOMINAL_S - DOUBT_TOL_S) || (e > NOMINAL_S + DOUBT_TOL_S);
  endfunction : off_nom

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic go;
    @(negedge clk_sys_in);
    {st, qt, pre, outs, loss, rreq, sreq} = {p_st, p_q, p_pre, p_out, p_loss, p_r, p_s};
    sval = p_v;
    offs = p_off;
    sel  = p_sel;
    {p_st, p_q, p_pre, p_out, p_loss, p_r, p_s} = '0;
  endtask : go

  task automatic live;
    chk("count", ec, cnt);
    chk("elapsed", ee, el);
    chk("doubt", ed, dbt);
  endtask : live

  task automatic secs(input int n, input int vmax);
    for (int i = 0; i < n; i++) begin
      p_s = 1'b1;
      p_v = (vmax < 0) ? 16'hffff : 16'($urandom_range(vmax, 0));
      ec  = sat(ec + int'(p_v), CMAX);
      ee  = sat(ee + 1, EMAX);
      if (ee > NOMINAL_S + DOUBT_TOL_S) ed = 1'b1;
      go;
    end
    go;
  endtask : secs

  task automatic hand(input logic by_set, input logic with_sec, input logic [15:0] v);
    lc = hc;
    le = he;
    ld = hd;
    hc = ec;
    he = ee;
    hd = ed | first | off_nom(ee);
    p_out = by_set;
    p_q   = ~by_set;
    p_s   = with_sec;
    p_v   = v;
    go;
    go;
    ec    = with_sec ? v : 0;
    ee    = with_sec;
    ed    = 1'b0;
    first = 1'b0;
    live;
    go;
    chk("hist_cnt", hc, hcnt);
    chk("hist_el", he, hel);
    chk("hist_doubt", hd, hdbt);
  endtask : hand

  task automatic preset(input int o);
    p_pre = 1'b1;
    p_off = OFFSET_W'(o);
    go;
    go;
    if (o > DOUBT_TOL_S || o < -DOUBT_TOL_S) ed = 1'b1;
    chk("doubt", ed, dbt);
  endtask : preset

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12000) @(posedge clk_sys_in);
    error_cnt++;
    conclude;
  end

  initial begin
    void'($urandom(85964));
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    live;
    p_s = 1'b1;
    p_v = 16'h0005;
    go;
    go;
    live;
    $display("test idle done");
    p_st = 1'b1;
    go;
    go;
    first = 1'b1;
    live;
    go;
    chk("hist_doubt", 1, hdbt);
    chk("hist_el", 0, hel);
    hc = 0;
    he = 0;
    hd = 1'b1;
    $display("test start done");
    secs(900, 2399);
    live;
    hand(1'b0, 1'b0, 16'h0000);
    secs(899, 2399);
    hand(1'b0, 1'b1, 16'h0007);
    p_sel = 4'h1;
    go;
    go;
    chk("slot1_cnt", lc, hcnt);
    chk("slot1_doubt", ld, hdbt);
    p_sel = 4'h0;
    go;
    $display("test intervals done");
    preset(10);
    preset(-11);
    hand(1'b1, 1'b0, 16'h0000);
    p_loss = 1'b1;
    go;
    go;
    ed = 1'b1;
    live;
    p_q    = 1'b1;
    p_loss = 1'b1;
    go;
    go;
    live;
    hand(1'b0, 1'b0, 16'h0000);
    $display("test doubt done");
    secs(1030, -1);
    live;
    p_r = 1'b1;
    go;
    go;
    chk("rep_valid", 1, rv);
    chk("rep_cnt", ec, rcnt);
    chk("rep_el", ee, rel);
    chk("rep_doubt", ed, rdbt);
    go;
    chk("rep_valid", 0, rv);
    chk("rep_cnt", ec, rcnt);
    hand(1'b0, 1'b0, 16'h0000);
    $display("test saturation done");
    secs(5, 100);
    p_st = 1'b1;
    go;
    go;
    {ec, ee, ed} = '0;
    live;
    go;
    chk("hist_doubt", 1, hdbt);
    $display("test restart done");
    conclude;
  end
endmodule : tb
`default_nettype wire
